// ### rtl/pfs_pkg.sv
// pin function setting package: shared widths, reset values and carriers
// assumes one system clock domain; no register bus, settings are ports
package pfs_pkg;

   // ---------------------------------------------------------------
   // port widths
   // ---------------------------------------------------------------
   localparam int PA_W = 8;
   localparam int PB_W = 4;
   localparam int PC_W = 6;
   localparam int PC_SEL_W = 2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [PA_W-1:0] PA_RST = 8'h00;
   localparam logic [PB_W-1:0] PB_RST = 4'h0;
   localparam logic [PC_W-1:0] PC_RST = 6'h00;
   localparam logic [PC_SEL_W-1:0] PC_SEL_RST = 2'h0;

   // ---------------------------------------------------------------
   // implemented-bit masks (unimplemented bits read 0, ignore writes)
   // ---------------------------------------------------------------
   localparam logic [PA_W-1:0] PA_FS_MASK = 8'h80; // timer capture, pin 7
   localparam logic [PC_W-1:0] PC_FS_MASK = 6'h1F; // i2c + serial 0 pins
   localparam logic [PC_W-1:0] PC_OUT_FN  = 6'h1C; // serial 0 outputs
   localparam logic [PC_W-1:0] PC_OD_FN   = 6'h03; // i2c open drain pins
   localparam int PA_EXTERNAL_INTERRUPT_ONE_BIT = 5;
   localparam int PA_EXTERNAL_INTERRUPT_TWO_BIT = 6;
   localparam int PA_TCAP_BIT = 7;
   localparam int PC_EXTERNAL_INTERRUPT_FOUR_BIT = 5;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   // fields sized for the widest port; narrower ports keep upper bits 0
   typedef struct packed {
      logic [PA_W-1:0] data;
      logic [PA_W-1:0] oe;
      logic [PA_W-1:0] fsel;
      logic [PA_W-1:0] od;
      logic [PA_W-1:0] pu;
      logic [PA_W-1:0] pd;
      logic [PA_W-1:0] ie;
   } pfs_cfg_s;

   typedef struct packed {
      logic [PA_W-1:0] out;
      logic [PA_W-1:0] oe;
      logic [PA_W-1:0] pu;
      logic [PA_W-1:0] pd;
      logic [PA_W-1:0] ie;
   } pfs_pad_s;

endpackage

// ### rtl/pfs_pin_port.sv
// one generic port: settings registers, pad drive and input sampling
// assumes write strobes and data come from logic on the same clock
`timescale 1ns/10ps
module pfs_pin_port #(
   parameter int W = 8,
   parameter logic [W-1:0] FS_MASK = '0,
   parameter logic [W-1:0] OD_MASK = '1,
   parameter logic [W-1:0] PULL_MASK = '1
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   // settings writes
   input  wire logic         wr_en,
   input  wire pfs_pkg::pfs_cfg_s wr_cfg,
   // peripheral side
   input  wire logic [W-1:0] fn_out,
   input  wire logic [W-1:0] fn_oe,
   input  wire logic [W-1:0] fn_od,
   // pad
   input  wire logic [W-1:0] pad_in,
   // results
   output pfs_pkg::pfs_cfg_s rd_cfg,
   output pfs_pkg::pfs_pad_s pad,
   output logic [W-1:0]      pin_level
);
   import pfs_pkg::*;

   pfs_cfg_s        cfg_r, cfg_nxt;
   pfs_pad_s        pad_r, pad_nxt;
   logic [W-1:0]    sync1_r, sync2_r, lvl_r, lvl_nxt;

   // pins that exist on this port; all other carrier bits stay 0
   localparam logic [PA_W-1:0] PIN_MASK = PA_W'({W{1'b1}});

   // -----------------------------------------------------------------
   // settings
   // -----------------------------------------------------------------
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_en) begin
         cfg_nxt.data = wr_cfg.data & PIN_MASK; // RULE16
         cfg_nxt.oe   = wr_cfg.oe   & PIN_MASK; // RULE16
         cfg_nxt.fsel = wr_cfg.fsel & PA_W'(FS_MASK); // RULE16 RULE13
         cfg_nxt.od   = wr_cfg.od   & PA_W'(OD_MASK); // RULE16
         cfg_nxt.pu   = wr_cfg.pu   & PA_W'(PULL_MASK); // RULE16
         cfg_nxt.pd   = wr_cfg.pd   & PA_W'(PULL_MASK); // RULE16
         cfg_nxt.ie   = wr_cfg.ie   & PIN_MASK; // RULE16
      end
      // data bits of input pins show the sampled level; the new oe is
      // used so that data written together with oe is not lost
      cfg_nxt.data = (cfg_nxt.data & cfg_nxt.oe)
                   | (PA_W'(lvl_r) & ~cfg_nxt.oe); // RULE3 RULE4 RULE15
   end

   // -----------------------------------------------------------------
   // pad drive
   // -----------------------------------------------------------------
   always_comb begin
      logic [W-1:0] src, oe, od;
      src = '0;
      oe  = '0;
      od  = '0;
      for (int i = 0; i < W; i++) begin
         // function bit 0 keeps port control, 1 hands over the pin
         src[i] = cfg_r.fsel[i] ? fn_out[i] : cfg_r.data[i]; // RULE13
         oe[i]  = cfg_r.oe[i] & (cfg_r.fsel[i] ? fn_oe[i] : 1'b1); // RULE4
         od[i]  = cfg_r.od[i] | (cfg_r.fsel[i] & fn_od[i]);
      end
      pad_nxt     = '0;
      pad_nxt.out = PA_W'(src);
      // pseudo open drain: a high output turns the buffer off
      pad_nxt.oe  = PA_W'(oe & ~(od & src)); // RULE14
      pad_nxt.pu  = cfg_r.pu;
      pad_nxt.pd  = cfg_r.pd;
      pad_nxt.ie  = cfg_r.ie; // RULE5
      lvl_nxt     = sync2_r & cfg_r.ie[W-1:0]; // RULE3
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r   <= '0; // RULE1 RULE2 RULE12
         pad_r   <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
         lvl_r   <= '0;
      end else begin
         cfg_r   <= cfg_nxt;
         pad_r   <= pad_nxt;
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
         lvl_r   <= lvl_nxt;
      end
   end

   assign rd_cfg    = cfg_r;
   assign pad       = pad_r;
   assign pin_level = lvl_r;

endmodule // pfs_pin_port

// ### rtl/pfs_top.sv
// pin function setting for ports a, b and c
// assumes settings arrive as same-clock write strobes, pads are external
//
// What this block does
// RULE1 - port a control bits reset to zero
// RULE2 - port c function and voltage bits reset
// RULE3 - input needs output off, input on
// RULE4 - output needs output on, input off
// RULE5 - analog input: no output, pulls, input
// RULE6 - interrupts need input only, no function
// RULE7 - timer capture via function bit pin seven
// RULE8 - i2c: function, output, open drain, input
// RULE9 - serial 0 via function, output, no input
// RULE10 - bus sense: input only, no function
// RULE11 - voltage select only on c pins zero, one
// RULE12 - port b plain only, reset zero
// RULE13 - function bit hands pin to peripheral
// RULE14 - open drain high disables buffer
// RULE15 - software waits after input enable
// RULE16 - unimplemented bits read zero, writes ignored
`timescale 1ns/10ps
module pfs_top
   import pfs_pkg::*;
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   reset_n,
   // settings writes, one strobe per port
   input  wire logic                   port_a_wr,
   input  wire logic                   port_b_wr,
   input  wire logic                   port_c_wr,
   input  wire pfs_pkg::pfs_cfg_s      wr_cfg,
   input  wire logic                   port_c_sel_wr,
   input  wire logic [pfs_pkg::PC_SEL_W-1:0] port_c_sel_wdata,
   // peripheral outputs on port c
   input  wire logic                   i2c_clock_out,
   input  wire logic                   i2c_data_out,
   input  wire logic                   serial0_tx_out,
   input  wire logic                   serial0_rx_out,
   input  wire logic                   serial0_clock_out,
   // pads
   input  wire logic [pfs_pkg::PA_W-1:0] port_a_pad_in,
   input  wire logic [pfs_pkg::PB_W-1:0] port_b_pad_in,
   input  wire logic [pfs_pkg::PC_W-1:0] port_c_pad_in,
   output pfs_pkg::pfs_pad_s           port_a_pad,
   output pfs_pkg::pfs_pad_s           port_b_pad,
   output pfs_pkg::pfs_pad_s           port_c_pad,
   output logic [pfs_pkg::PC_SEL_W-1:0] port_c_low_volt_r,
   // read back
   output pfs_pkg::pfs_cfg_s           port_a_cfg,
   output pfs_pkg::pfs_cfg_s           port_b_cfg,
   output pfs_pkg::pfs_cfg_s           port_c_cfg,
   // peripheral inputs
   output logic                        external_interrupt_one_r,
   output logic                        external_interrupt_two_r,
   output logic                        external_interrupt_four_r,
   output logic                        timer_capture_input_r,
   output logic                        bus_sense_r,
   output logic                        i2c_clock_in_r,
   output logic                        i2c_data_in_r,
   output logic [pfs_pkg::PA_W-1:0]    analog_enable_r
);

   // -----------------------------------------------------------------
   // ports
   // -----------------------------------------------------------------
   logic [PA_W-1:0] a_lvl;
   logic [PB_W-1:0] b_lvl;
   logic [PC_W-1:0] c_lvl;
   logic [PC_W-1:0] c_fn_out;
   logic [PC_SEL_W-1:0] sel_r, sel_nxt;
   logic ei1_nxt, ei2_nxt, ei4_nxt, tcap_nxt, vbus_nxt, scl_nxt, sda_nxt;
   logic [PA_W-1:0] ain_nxt;

   assign c_fn_out = {1'b0, serial0_clock_out, serial0_rx_out,
                      serial0_tx_out, i2c_data_out, i2c_clock_out};

   pfs_pin_port #(.W(PA_W), .FS_MASK(PA_FS_MASK)) u_port_a (
      .clock     (clock),
      .reset_n   (reset_n),
      .wr_en     (port_a_wr),
      .wr_cfg    (wr_cfg),
      .fn_out    ('0),
      .fn_oe     ('0),   // RULE7 capture is input only
      .fn_od     ('0),
      .pad_in    (port_a_pad_in),
      .rd_cfg    (port_a_cfg),
      .pad       (port_a_pad),
      .pin_level (a_lvl)
   );

   // port b carries no function select; open drain and pulls stay free
   pfs_pin_port #(.W(PB_W), .FS_MASK('0)) u_port_b (
      .clock     (clock),
      .reset_n   (reset_n),
      .wr_en     (port_b_wr),
      .wr_cfg    (wr_cfg),
      .fn_out    ('0),
      .fn_oe     ('0),
      .fn_od     ('0),
      .pad_in    (port_b_pad_in),
      .rd_cfg    (port_b_cfg),
      .pad       (port_b_pad),
      .pin_level (b_lvl)
   ); // RULE12

   // i2c pins may be released by the controller for a high level
   pfs_pin_port #(.W(PC_W), .FS_MASK(PC_FS_MASK)) u_port_c (
      .clock     (clock),
      .reset_n   (reset_n),
      .wr_en     (port_c_wr),
      .wr_cfg    (wr_cfg),
      .fn_out    (c_fn_out),
      .fn_oe     (PC_FS_MASK), // RULE9 RULE8
      .fn_od     (PC_OD_FN),   // RULE8
      .pad_in    (port_c_pad_in),
      .rd_cfg    (port_c_cfg),
      .pad       (port_c_pad),
      .pin_level (c_lvl)
   );

   // -----------------------------------------------------------------
   // peripheral input routing
   // -----------------------------------------------------------------
   always_comb begin
      sel_nxt = sel_r;
      if (port_c_sel_wr) begin
         sel_nxt = port_c_sel_wdata; // RULE11
      end
      // interrupts and bus sense need no function bit, only input on
      ei1_nxt  = a_lvl[PA_EXTERNAL_INTERRUPT_ONE_BIT]; // RULE6
      ei2_nxt  = a_lvl[PA_EXTERNAL_INTERRUPT_TWO_BIT]; // RULE6
      ei4_nxt  = c_lvl[PC_EXTERNAL_INTERRUPT_FOUR_BIT]; // RULE6
      vbus_nxt = c_lvl[PC_EXTERNAL_INTERRUPT_FOUR_BIT]; // RULE10
      tcap_nxt = a_lvl[PA_TCAP_BIT] & port_a_cfg.fsel[PA_TCAP_BIT]; // RULE7
      scl_nxt  = c_lvl[0] & port_c_cfg.fsel[0]; // RULE8
      sda_nxt  = c_lvl[1] & port_c_cfg.fsel[1]; // RULE8
      // analog path valid only with output, pulls and input all off
      ain_nxt  = ~(port_a_cfg.oe[PA_W-1:0] | port_a_cfg.pu[PA_W-1:0]
                 | port_a_cfg.pd[PA_W-1:0] | port_a_cfg.ie[PA_W-1:0]); // RULE5
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sel_r                     <= PC_SEL_RST; // RULE2 RULE11
         external_interrupt_one_r  <= 1'b0;
         external_interrupt_two_r  <= 1'b0;
         external_interrupt_four_r <= 1'b0;
         timer_capture_input_r     <= 1'b0;
         bus_sense_r               <= 1'b0;
         i2c_clock_in_r            <= 1'b0;
         i2c_data_in_r             <= 1'b0;
         analog_enable_r           <= '0;
         port_c_low_volt_r         <= '0;
      end else begin
         sel_r                     <= sel_nxt;
         external_interrupt_one_r  <= ei1_nxt;
         external_interrupt_two_r  <= ei2_nxt;
         external_interrupt_four_r <= ei4_nxt;
         timer_capture_input_r     <= tcap_nxt;
         bus_sense_r               <= vbus_nxt;
         i2c_clock_in_r            <= scl_nxt;
         i2c_data_in_r             <= sda_nxt;
         analog_enable_r           <= ain_nxt;
         // voltage select does nothing when the pin is a plain output
         port_c_low_volt_r <= sel_nxt
            & ~(port_c_cfg.oe[PC_SEL_W-1:0]
                & ~port_c_cfg.fsel[PC_SEL_W-1:0]); // RULE11
      end
   end

endmodule // pfs_top

// ### bench/pfs_top_properties.sv
// checker: port timing and bit masking of the pin setting block
// assumes it is bound to pfs_top and shares its single clock domain
`timescale 1ns/10ps
module pfs_top_checker
   import pfs_pkg::*;
(
   input wire logic                     clock,
   input wire logic                     reset_n,
   input wire logic                     port_c_wr,
   input wire pfs_pkg::pfs_cfg_s        wr_cfg,
   input wire pfs_pkg::pfs_cfg_s        port_a_cfg,
   input wire pfs_pkg::pfs_cfg_s        port_b_cfg,
   input wire pfs_pkg::pfs_cfg_s        port_c_cfg,
   input wire pfs_pkg::pfs_pad_s        port_c_pad,
   input wire logic [pfs_pkg::PC_SEL_W-1:0] port_c_low_volt_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_reset_clear: assert property ($rose(reset_n) |->
      port_a_cfg == '0 && port_b_cfg == '0 && port_c_cfg == '0
      && port_c_low_volt_r == '0) else $error("settings not clear");
   a_c_fsel_mask: assert property (port_c_cfg.fsel[5] == 1'b0)
      else $error("unused function bit set");
   a_b_plain_only: assert property (port_b_cfg.fsel == '0)
      else $error("plain port has a function bit");
   a_c_oe_load: assert property (port_c_wr |=>
      port_c_cfg.oe[PC_W-1:0] == $past(wr_cfg.oe[PC_W-1:0]) &&
      port_c_cfg.oe[PA_W-1:PC_W] == '0) else $error("oe not loaded");
   a_c_pad_off: assert property (port_c_wr && wr_cfg.oe == '0 |=>
      ##1 port_c_pad.oe == '0) else $error("pad driven while off");
   a_od_high_off: assert property (port_c_wr && wr_cfg.fsel == '0
      |=> ##1 (port_c_pad.oe & $past(wr_cfg.od & wr_cfg.data, 2)) == '0)
      else $error("open drain high still driven");
   a_out_drive: assert property (port_c_wr && wr_cfg.fsel == '0 &&
      wr_cfg.od == '0 |=> ##1
      port_c_pad.oe[PC_W-1:0] == $past(wr_cfg.oe[PC_W-1:0], 2) &&
      (port_c_pad.out[PC_W-1:0] & port_c_pad.oe[PC_W-1:0]) ==
      ($past(wr_cfg.data[PC_W-1:0], 2) & $past(wr_cfg.oe[PC_W-1:0], 2)))
      else $error("output drive wrong");
   a_pull_ie: assert property (port_c_wr |=> ##1
      port_c_pad.ie[PC_W-1:0] == $past(wr_cfg.ie[PC_W-1:0], 2) &&
      port_c_pad.pu[PC_W-1:0] == $past(wr_cfg.pu[PC_W-1:0], 2))
      else $error("pad ie or pull");
   c_function: cover property (port_c_wr && wr_cfg.fsel != '0);
   c_open_drain: cover property (port_c_wr && wr_cfg.od != '0);
   c_low_volt: cover property ($rose(port_c_low_volt_r[0]));
endmodule // pfs_top_checker

bind pfs_top pfs_top_checker u_chk (.clock, .reset_n, .port_c_wr, .wr_cfg,
   .port_a_cfg, .port_b_cfg, .port_c_cfg, .port_c_pad, .port_c_low_volt_r);

// ### bench/pfs_top_tb.sv
// testbench: directed scenarios for the pin setting block
// assumes the checker file is compiled alongside for the bind
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
   err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pfs_top_tb;
   import pfs_pkg::*;
   logic clock = 0, reset_n = 0, port_a_wr = 0, port_b_wr = 0, port_c_wr = 0;
   logic port_c_sel_wr = 0, i2c_clock_out = 0, i2c_data_out = 0;
   logic serial0_tx_out = 0, serial0_rx_out = 0, serial0_clock_out = 0;
   logic [PC_SEL_W-1:0] port_c_sel_wdata = '0, port_c_low_volt_r;
   logic [PA_W-1:0] port_a_pad_in = '0, analog_enable_r;
   logic [PB_W-1:0] port_b_pad_in = '0;
   logic [PC_W-1:0] port_c_pad_in = '0;
   pfs_cfg_s wr_cfg = '0, port_a_cfg, port_b_cfg, port_c_cfg;
   pfs_pad_s port_a_pad, port_b_pad, port_c_pad;
   logic external_interrupt_one_r, external_interrupt_two_r;
   logic external_interrupt_four_r, timer_capture_input_r, bus_sense_r;
   logic i2c_clock_in_r, i2c_data_in_r;
   int err_count = 0, tests_run = 0;
   pfs_top dut (
      .clock                     (clock),
      .reset_n                   (reset_n),
      .port_a_wr                 (port_a_wr),
      .port_b_wr                 (port_b_wr),
      .port_c_wr                 (port_c_wr),
      .wr_cfg                    (wr_cfg),
      .port_c_sel_wr             (port_c_sel_wr),
      .port_c_sel_wdata          (port_c_sel_wdata),
      .i2c_clock_out             (i2c_clock_out),
      .i2c_data_out              (i2c_data_out),
      .serial0_tx_out            (serial0_tx_out),
      .serial0_rx_out            (serial0_rx_out),
      .serial0_clock_out         (serial0_clock_out),
      .port_a_pad_in             (port_a_pad_in),
      .port_b_pad_in             (port_b_pad_in),
      .port_c_pad_in             (port_c_pad_in),
      .port_a_pad                (port_a_pad),
      .port_b_pad                (port_b_pad),
      .port_c_pad                (port_c_pad),
      .port_c_low_volt_r         (port_c_low_volt_r),
      .port_a_cfg                (port_a_cfg),
      .port_b_cfg                (port_b_cfg),
      .port_c_cfg                (port_c_cfg),
      .external_interrupt_one_r  (external_interrupt_one_r),
      .external_interrupt_two_r  (external_interrupt_two_r),
      .external_interrupt_four_r (external_interrupt_four_r),
      .timer_capture_input_r     (timer_capture_input_r),
      .bus_sense_r               (bus_sense_r),
      .i2c_clock_in_r            (i2c_clock_in_r),
      .i2c_data_in_r             (i2c_data_in_r),
      .analog_enable_r           (analog_enable_r)
   );
   initial forever #10 clock = ~clock;
   // ---------------------------------------------------------------
   // bus tasks; settle wait covers the four cycle input path
   // ---------------------------------------------------------------
   task automatic wr(input int p, input pfs_cfg_s c);
      @(negedge clock);
      wr_cfg = c;
      {port_c_wr, port_b_wr, port_a_wr} = 3'h1 << p;
      @(negedge clock);
      {port_c_wr, port_b_wr, port_a_wr} = 3'h0;
      repeat (6) @(negedge clock);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      `CHK("a cfg", 42'h0, port_a_cfg)
      `CHK("b cfg", 42'h0, port_b_cfg)
      `CHK("c cfg", 42'h0, port_c_cfg)
      `CHK("c sel", 2'h0, port_c_low_volt_r)
      repeat (3) @(negedge clock);
      `CHK("analog", 8'hFF, analog_enable_r)
      $display("test reset done");
   endtask
   task automatic t_output();
      wr(2, '{8'h2A, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK("c oe", 6'h3F, port_c_pad.oe)
      `CHK("c out", 6'h2A, port_c_pad.out)
      wr(2, '{8'h0F, 8'h3F, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00});
      `CHK("od oe", 6'h30, port_c_pad.oe)
      $display("test output done");
   endtask
   task automatic t_input();
      port_c_pad_in = 6'h25;
      port_a_pad_in = 8'h20;
      wr(2, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F});
      wr(0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21});
      `CHK("c data", 6'h25, port_c_cfg.data)
      `CHK("c oe", 6'h00, port_c_pad.oe)
      `CHK("bus sense", 1'b1, bus_sense_r)
      `CHK("int four", 1'b1, external_interrupt_four_r)
      `CHK("int one", 1'b1, external_interrupt_one_r)
      `CHK("analog", 2'h1, {analog_enable_r[5], analog_enable_r[1]})
      $display("test input done");
   endtask
   task automatic t_function();
      {serial0_tx_out, serial0_rx_out, serial0_clock_out} = 3'h5;
      wr(1, '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK("b fsel", 6'h00, port_b_cfg.fsel)
      wr(2, '{8'h00, 8'h1C, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK("c fsel", 6'h1F, port_c_cfg.fsel)
      `CHK("serial oe", 3'h7, port_c_pad.oe[4:2])
      `CHK("serial out", 3'h5, port_c_pad.out[4:2])
      $display("test function done");
   endtask
   task automatic t_i2c();
      {i2c_clock_out, i2c_data_out} = 2'h3;
      port_c_pad_in = 6'h02;
      wr(2, '{8'h00, 8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03});
      `CHK("i2c clk", 1'b0, i2c_clock_in_r)
      `CHK("i2c dat", 1'b1, i2c_data_in_r)
      `CHK("i2c oe", 2'h0, port_c_pad.oe[1:0])
      @(negedge clock);
      port_c_sel_wr = 1;
      port_c_sel_wdata = 2'h3;
      @(negedge clock);
      port_c_sel_wr = 0;
      repeat (6) @(negedge clock);
      `CHK("sel i2c", 2'h3, port_c_low_volt_r)
      wr(2, '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK("sel out", 2'h0, port_c_low_volt_r)
      $display("test i2c done");
   endtask
   // reset in mid run must also clear the voltage select held from i2c
   task automatic t_mid_reset();
      wr(2, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03});
      `CHK("sel in", 2'h3, port_c_low_volt_r)
      reset_n = 0;
      repeat (2) @(negedge clock);
      reset_n = 1;
      @(negedge clock);
      `CHK("c cfg rst", 56'h0, port_c_cfg)
      `CHK("a cfg rst", 56'h0, port_a_cfg)
      `CHK("c pad rst", 40'h0, port_c_pad)
      wr(2, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03});
      `CHK("sel rst", 2'h0, port_c_low_volt_r)
      $display("test mid reset done");
   endtask
   task automatic t_port_ab();
      wr(0, '{8'hC3, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK("a out", 8'hC3, port_a_pad.out)
      `CHK("a oe", 8'hFF, port_a_pad.oe)
      port_a_pad_in = 8'hC0;
      wr(0, '{8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'hC0});
      `CHK("a fsel", 8'h80, port_a_cfg.fsel)
      `CHK("a data", 8'hC0, port_a_cfg.data)
      `CHK("a pad oe", 8'h00, port_a_pad.oe)
      `CHK("capture", 1'b1, timer_capture_input_r)
      `CHK("int two", 1'b1, external_interrupt_two_r)
      wr(1, '{8'h05, 8'h0F, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00});
      `CHK("b out", 8'h05, port_b_pad.out)
      `CHK("b oe", 8'h0F, port_b_pad.oe)
      `CHK("b pull", 8'h0A, port_b_pad.pu)
      $display("test ports a b done");
   endtask
   initial begin
      repeat (16) @(negedge clock);
      reset_n = 1;
      @(negedge clock);
      t_reset();
      t_output();
      t_input();
      t_function();
      t_i2c();
      t_mid_reset();
      t_port_ab();
      tally_and_finish();
   end
   initial begin
      #60000;
      err_count++;
      tally_and_finish();
   end
endmodule // pfs_top_tb
